// ### pci_target_port.sv
// Bus target port: claims configuration cycles, serves a ROM-loaded image.
// Assumes the testbench resolves the shared bus lines from the enables.
`timescale 1ns/10ps
`default_nettype none
`include "pci_tgt_defs.svh"

// Notes on behaviour
// - Everything runs on the one bus clock
// - Reset floats all driven lines, clears state
// - Address phase then data phases, same lines
// - Write data taken only with both readies
// - Target ready only when phase can complete
// - Stop asks initiator to end the transaction
// - Configuration cycles claimed only with idsel
// - Device select after decoding own address
// - Data parity errors reported, at least one clock
// - Address parity error pulls system error
// - Even parity over data and command lines
// - Parity valid one clock after its data
// - Command in address phase, enables after
// - Interrupt line pulled while condition present
// - Load image from ROM after reset
// - Strap low skips ROM, defaults used
module pci_target_port #(
  parameter int ROM_HALF_CYC = `ROM_HALF_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Address/data and command lines
  input wire logic [31:0] ad_i,
  output logic [31:0] ad_o,
  output logic ad_oe_o,
  input wire logic [3:0] cbe_n_i,
  input wire logic par_i,
  output logic par_o,
  output logic par_oe_o,
  // Handshake
  input wire logic frame_n_i,
  input wire logic irdy_n_i,
  input wire logic lock_n_i,
  input wire logic idsel_i,
  output logic trdy_n_o,
  output logic trdy_oe_o,
  output logic stop_n_o,
  output logic stop_oe_o,
  output logic devsel_n_o,
  output logic devsel_oe_o,
  // Error and interrupt lines
  output logic perr_n_o,
  output logic perr_oe_o,
  output logic serr_oe_o,
  output logic int_oe_o,
  input wire logic irq_i,
  // Configuration ROM
  input wire logic cfg_rom_enable_strap_i,
  input wire logic cfg_rom_data_in_i,
  output logic cfg_rom_select_o,
  output logic cfg_rom_clock_o,
  output logic cfg_rom_data_out_o,
  // Configuration writes to the user side
  output pci_tgt_pkg::cfg_wr_t cfg_wr_o,
  output logic load_done_o
);
  pci_tgt_pkg::tgt_state_t state_ff, nxt_state;
  pci_tgt_pkg::bus_drv_t drv_ff, nxt_drv;
  pci_tgt_pkg::cfg_wr_t wr_ff, nxt_wr;
  pci_tgt_pkg::rom_wr_t rom_wr;
  logic [31:0] img_ff [`CFG_DWORDS]; // Read-only configuration image
  logic [31:0] ad_ff, nxt_ad; // Read data driven
  logic [5:0] idx_ff, nxt_idx; // Latched dword index
  logic rd_ff, nxt_rd; // Transaction is a read
  logic frame_q_ff; // Frame of the previous cycle
  logic addr_chk_ff, nxt_addr_chk;
  logic data_chk_ff, nxt_data_chk;
  logic int_ff;
  logic rom_done;
  logic start; // Address phase on the bus
  logic hit; // Address phase is ours
  logic [31:0] rd_word;

  // Lock is accepted and ignored: this target holds no lockable resource
  // A locked sequence is served like any other, one dword at a time

  // Address decode: command lines carry the command here
  always_comb begin
    start = !frame_n_i && frame_q_ff && state_ff == pci_tgt_pkg::ST_IDLE;
    hit = start && idsel_i && cbe_n_i[3:1] == `CMD_CFG_HI &&
          ad_i[1:0] == 2'h0;
    rd_word = '0;
    if (ad_i[`CFG_IDX_HI:`CFG_IDX_LO] < 6'(`CFG_DWORDS)) begin
      rd_word = img_ff[ad_i[`CFG_IDX_HI - 2:`CFG_IDX_LO]];
    end
  end

  // Sequencer next values
  always_comb begin
    nxt_state = state_ff;
    nxt_drv = drv_ff;
    nxt_ad = ad_ff;
    nxt_idx = idx_ff;
    nxt_rd = rd_ff;
    nxt_wr = '0;
    nxt_addr_chk = start; // Address parity follows one clock later
    nxt_data_chk = 1'h0;
    case (state_ff)
      pci_tgt_pkg::ST_IDLE: begin
        nxt_drv = '{ad_oe: 1'h0, ctl_oe: 1'h0, trdy_n: 1'h1, stop_n: 1'h1,
                    devsel_n: 1'h1};
        if (hit) begin
          // Claim on the clock after the address phase
          nxt_state = pci_tgt_pkg::ST_CLAIM;
          nxt_drv.ctl_oe = 1'h1;
          nxt_drv.devsel_n = 1'h0;
          nxt_rd = !cbe_n_i[`CMD_WR_BIT];
          nxt_idx = ad_i[`CFG_IDX_HI:`CFG_IDX_LO];
          nxt_ad = rd_word;
        end
      end
      pci_tgt_pkg::ST_CLAIM: begin
        // Turnaround cycle; data and ready come next
        if (!rom_done) begin
          nxt_state = pci_tgt_pkg::ST_RETRY; // Image incomplete
          nxt_drv.stop_n = 1'h0;
        end else begin
          nxt_state = pci_tgt_pkg::ST_DATA;
          nxt_drv.ad_oe = rd_ff;
          nxt_drv.trdy_n = 1'h0;
          // One dword per access: disconnect a burst with its data
          nxt_drv.stop_n = frame_n_i;
        end
      end
      pci_tgt_pkg::ST_DATA: begin
        if (!irdy_n_i) begin
          // Both readies seen: the phase completes here
          nxt_wr = '{valid: !rd_ff, idx: idx_ff, data: ad_i,
                     be: ~cbe_n_i}; // Enables active low, lane n
          nxt_data_chk = !rd_ff;
          nxt_drv.trdy_n = 1'h1;
          nxt_drv.ad_oe = 1'h0;
          if (frame_n_i) begin
            nxt_state = pci_tgt_pkg::ST_RELEASE;
            nxt_drv.devsel_n = 1'h1;
            nxt_drv.stop_n = 1'h1;
          end else begin
            nxt_state = pci_tgt_pkg::ST_WAIT_END;
            nxt_drv.stop_n = 1'h0;
          end
        end
      end
      pci_tgt_pkg::ST_RETRY, pci_tgt_pkg::ST_WAIT_END: begin
        // Stop held until the initiator drops frame
        if (frame_n_i) begin
          nxt_state = pci_tgt_pkg::ST_RELEASE;
          nxt_drv.devsel_n = 1'h1;
          nxt_drv.stop_n = 1'h1;
        end
      end
      pci_tgt_pkg::ST_RELEASE: begin
        // Lines were driven high one cycle; now float them
        nxt_state = pci_tgt_pkg::ST_IDLE;
        nxt_drv.ctl_oe = 1'h0;
      end
      default: nxt_state = pci_tgt_pkg::ST_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_ff <= pci_tgt_pkg::ST_IDLE;
      drv_ff <= '{ad_oe: 1'h0, ctl_oe: 1'h0, trdy_n: 1'h1, stop_n: 1'h1,
                  devsel_n: 1'h1};
      ad_ff <= '0;
      idx_ff <= '0;
      rd_ff <= 1'h0;
      wr_ff <= '0;
      frame_q_ff <= 1'h1;
      addr_chk_ff <= 1'h0;
      data_chk_ff <= 1'h0;
      int_ff <= 1'h0;
    end else begin
      state_ff <= nxt_state;
      drv_ff <= nxt_drv;
      ad_ff <= nxt_ad;
      idx_ff <= nxt_idx;
      rd_ff <= nxt_rd;
      wr_ff <= nxt_wr;
      frame_q_ff <= frame_n_i;
      addr_chk_ff <= nxt_addr_chk;
      data_chk_ff <= nxt_data_chk;
      int_ff <= irq_i;
    end
  end

  // Image store: defaults at reset, overwritten word by word from the ROM
  // Bus writes are only exported, so software cannot alter the image
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < `CFG_DWORDS; i++) begin
        img_ff[i] <= (i == 0) ? {`DEF_DEVICE, `DEF_VENDOR} : '0;
      end
    end else if (rom_wr.valid && rom_wr.idx[0]) begin
      img_ff[rom_wr.idx[4:1]][31:16] <= rom_wr.data;
    end else if (rom_wr.valid) begin
      img_ff[rom_wr.idx[4:1]][15:0] <= rom_wr.data;
    end
  end

  // Parity generation and error reporting
  pci_parity_unit u_parity (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ad_i(ad_i),
    .cbe_n_i(cbe_n_i),
    .ad_drv_i(ad_ff),
    .ad_oe_i(drv_ff.ad_oe),
    .par_i(par_i),
    .addr_chk_i(addr_chk_ff),
    .data_chk_i(data_chk_ff),
    .par_o(par_o),
    .par_oe_o(par_oe_o),
    .perr_n_o(perr_n_o),
    .perr_oe_o(perr_oe_o),
    .serr_oe_o(serr_oe_o)
  );

  // Serial image loader, run once per reset
  cfg_rom_loader #(.HALF_CYC(ROM_HALF_CYC)) u_loader (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .cfg_rom_enable_strap_i(cfg_rom_enable_strap_i),
    .cfg_rom_data_in_i(cfg_rom_data_in_i),
    .cfg_rom_select_o(cfg_rom_select_o),
    .cfg_rom_clock_o(cfg_rom_clock_o),
    .cfg_rom_data_out_o(cfg_rom_data_out_o),
    .wr_o(rom_wr),
    .done_o(rom_done)
  );

  // Pin mapping, all from flip-flops
  assign ad_o = ad_ff;
  assign ad_oe_o = drv_ff.ad_oe;
  assign trdy_n_o = drv_ff.trdy_n;
  assign trdy_oe_o = drv_ff.ctl_oe;
  assign stop_n_o = drv_ff.stop_n;
  assign stop_oe_o = drv_ff.ctl_oe;
  assign devsel_n_o = drv_ff.devsel_n;
  assign devsel_oe_o = drv_ff.ctl_oe;
  assign int_oe_o = int_ff;
  assign cfg_wr_o = wr_ff;
  assign load_done_o = rom_done;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // Steps of a claimed access
  sequence s_burst_claim;
    state_ff == pci_tgt_pkg::ST_CLAIM && rom_done && !frame_n_i;
  endsequence
  sequence s_claim_read;
    hit && !cbe_n_i[`CMD_WR_BIT] && rom_done;
  endsequence
  sequence s_drive_read;
    !devsel_n_o && !ad_oe_o ##1 ad_oe_o && !trdy_n_o;
  endsequence

  // Claim, handshake and interrupt checks
  a_devsel_claim: assert property (hit |=> !devsel_n_o && devsel_oe_o)
    else $error("claim missing");
  a_idsel_only: assert property (start && !idsel_i |=> devsel_n_o)
    else $error("claimed without idsel");
  a_trdy_ready: assert property (!trdy_n_o |-> rom_done &&
    state_ff == pci_tgt_pkg::ST_DATA) else $error("ready too early");
  a_write_take: assert property (cfg_wr_o.valid |->
    $past(!irdy_n_i && !trdy_n_o && !rd_ff)) else $error("write without readies");
  a_retry_stop: assert property (state_ff == pci_tgt_pkg::ST_CLAIM && !rom_done |=>
    !stop_n_o && trdy_n_o) else $error("retry missing");
  a_read_turn: assert property (s_claim_read |=> s_drive_read)
    else $error("read data phase wrong");
  a_release_float: assert property (state_ff == pci_tgt_pkg::ST_RELEASE |->
    devsel_n_o && trdy_n_o ##1 !devsel_oe_o) else $error("lines not released");
  a_int_follow: assert property ($rose(irq_i) |=> int_oe_o)
    else $error("interrupt not driven");
  a_int_clear: assert property (!irq_i |=> !int_oe_o)
    else $error("interrupt held");

  // Disconnect, byte lanes and idle float
  a_burst_stop: assert property (s_burst_claim |=> !stop_n_o && !trdy_n_o)
    else $error("burst not disconnected");
  a_write_lanes: assert property (state_ff == pci_tgt_pkg::ST_DATA &&
    !irdy_n_i && !rd_ff |=> cfg_wr_o.valid && cfg_wr_o.be == ~$past(cbe_n_i))
    else $error("byte enables wrong");
  a_idle_float: assert property (state_ff == pci_tgt_pkg::ST_IDLE |->
    !ad_oe_o && !devsel_oe_o) else $error("lines driven while idle");
endmodule
`default_nettype wire

// ### pci_tgt_defs.svh
// Constants of the bus target and its configuration ROM loader.
// Assumes a 200 MHz core clock; included by bare name.
`ifndef PCI_TGT_DEFS_SVH
`define PCI_TGT_DEFS_SVH

// Bus commands claimed by this target
`define CMD_CFG_HI 3'h5
`define CMD_WR_BIT 0
// Dword index field of a configuration address
`define CFG_IDX_HI 7
`define CFG_IDX_LO 2
`define CFG_DWORDS 16
// Default identity, values arbitrary
`define DEF_VENDOR 16'h1234
`define DEF_DEVICE 16'h5678
// Serial ROM geometry and command
`define ROM_WORDS 32
`define ROM_AW 6
`define ROM_DW 16
`define ROM_CMD_BITS 9
`define ROM_OP_READ 3'h6
`define ROM_EDGES 25
// Serial ROM clock half period, least time
`define CLK_PERIOD_NS 5
`define ROM_HALF_NS 500
`define ROM_HALF_CYC ((`ROM_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### pci_tgt_pkg.sv
// Types shared by the bus target and its ROM loader.
// Assumes the constants header is read first.
package pci_tgt_pkg;
  // Target sequencer states
  typedef enum logic [2:0] {ST_IDLE, ST_CLAIM, ST_DATA, ST_RETRY, ST_WAIT_END,
                            ST_RELEASE} tgt_state_t;
  // ROM loader states
  typedef enum logic [1:0] {LD_STRAP, LD_SHIFT, LD_GAP, LD_DONE} ld_state_t;
  // Target-driven control lines
  typedef struct packed {
    logic ad_oe;
    logic ctl_oe;
    logic trdy_n;
    logic stop_n;
    logic devsel_n;
  } bus_drv_t;
  // Configuration write seen on the bus
  typedef struct packed {
    logic valid;
    logic [5:0] idx;
    logic [31:0] data;
    logic [3:0] be;
  } cfg_wr_t;
  // One word fetched from the serial ROM
  typedef struct packed {
    logic valid;
    logic [4:0] idx;
    logic [15:0] data;
  } rom_wr_t;
endpackage

// ### pci_parity_unit.sv
// Even parity generation for read data and checking of address/write data.
// Assumes check strobes arrive in the cycle where the parity bit is valid.
`timescale 1ns/10ps
`default_nettype none
`include "pci_tgt_defs.svh"

module pci_parity_unit (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Bus levels and own drive
  input wire logic [31:0] ad_i,
  input wire logic [3:0] cbe_n_i,
  input wire logic [31:0] ad_drv_i,
  input wire logic ad_oe_i,
  input wire logic par_i,
  // Check strobes
  input wire logic addr_chk_i,
  input wire logic data_chk_i,
  // Parity and error pins
  output logic par_o,
  output logic par_oe_o,
  output logic perr_n_o,
  output logic perr_oe_o,
  output logic serr_oe_o
);
  logic calc_ff, nxt_calc; // Parity of the previous cycle
  logic par_oe_ff, nxt_par_oe;
  logic perr_n_ff, nxt_perr_n;
  logic perr_oe_ff, nxt_perr_oe;
  logic serr_ff, nxt_serr;
  logic [31:0] src; // Own data wins while driving

  // Next values
  always_comb begin
    src = ad_oe_i ? ad_drv_i : ad_i;
    nxt_calc = ^{src, cbe_n_i};
    nxt_par_oe = ad_oe_i; // Lags data by one clock
    nxt_serr = addr_chk_i && (par_i != calc_ff);
    nxt_perr_n = !(data_chk_i && (par_i != calc_ff));
    // Keep driving one cycle after an error to return the line high
    nxt_perr_oe = data_chk_i || !perr_n_ff;
  end

  // Registers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      calc_ff <= 1'h0;
      par_oe_ff <= 1'h0;
      perr_n_ff <= 1'h1;
      perr_oe_ff <= 1'h0;
      serr_ff <= 1'h0;
    end else begin
      calc_ff <= nxt_calc;
      par_oe_ff <= nxt_par_oe;
      perr_n_ff <= nxt_perr_n;
      perr_oe_ff <= nxt_perr_oe;
      serr_ff <= nxt_serr;
    end
  end

  assign par_o = calc_ff;
  assign par_oe_o = par_oe_ff;
  assign perr_n_o = perr_n_ff;
  assign perr_oe_o = perr_oe_ff;
  assign serr_oe_o = serr_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_par_even: assert property (par_oe_o |->
    par_o == ^{$past(ad_drv_i), $past(cbe_n_i)}) else $error("read parity wrong");
  a_serr_addr: assert property (addr_chk_i && !$past(ad_oe_i) &&
    (par_i != ^$past({ad_i, cbe_n_i})) |=> serr_oe_o) else $error("addr parity missed");
  a_perr_hold: assert property (!perr_n_o |-> perr_oe_o ##1 perr_oe_o)
    else $error("perr not held");
endmodule
`default_nettype wire

// ### cfg_rom_loader.sv
// Serial configuration ROM reader run once after reset.
// Assumes a three-wire ROM with 16-bit words and a read opcode 110.
`timescale 1ns/10ps
`default_nettype none
`include "pci_tgt_defs.svh"

module cfg_rom_loader #(
  parameter int HALF_CYC = `ROM_HALF_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // ROM pins and strap
  input wire logic cfg_rom_enable_strap_i,
  input wire logic cfg_rom_data_in_i,
  output logic cfg_rom_select_o,
  output logic cfg_rom_clock_o,
  output logic cfg_rom_data_out_o,
  // Fetched words
  output pci_tgt_pkg::rom_wr_t wr_o,
  output logic done_o
);
  pci_tgt_pkg::ld_state_t state_ff, nxt_state;
  logic [15:0] div_ff, nxt_div; // Half period timer
  logic [4:0] bit_ff, nxt_bit; // Rising edges done
  logic [4:0] idx_ff, nxt_idx; // Word address
  logic [8:0] cmd_ff, nxt_cmd; // Command shifter
  logic [15:0] din_ff, nxt_din; // Data shifter
  logic cs_ff, nxt_cs, sck_ff, nxt_sck;
  pci_tgt_pkg::rom_wr_t wr_ff, nxt_wr;
  logic done_ff, nxt_done;
  logic tick; // Half period over

  // Next values
  always_comb begin
    nxt_state = state_ff;
    nxt_div = div_ff;
    nxt_bit = bit_ff;
    nxt_idx = idx_ff;
    nxt_cmd = cmd_ff;
    nxt_din = din_ff;
    nxt_cs = cs_ff;
    nxt_sck = sck_ff;
    nxt_wr = '0;
    nxt_done = done_ff;
    tick = (div_ff == 16'(HALF_CYC - 1));
    if (state_ff == pci_tgt_pkg::LD_SHIFT || state_ff == pci_tgt_pkg::LD_GAP) begin
      nxt_div = tick ? '0 : div_ff + 16'h1;
    end
    case (state_ff)
      pci_tgt_pkg::LD_STRAP: begin
        // Strap caught one clock after reset release
        if (!cfg_rom_enable_strap_i) begin
          nxt_state = pci_tgt_pkg::LD_DONE;
          nxt_done = 1'h1;
        end else begin
          nxt_state = pci_tgt_pkg::LD_SHIFT;
          nxt_cs = 1'h1;
          nxt_cmd = {`ROM_OP_READ, 6'(idx_ff)};
        end
      end
      pci_tgt_pkg::LD_SHIFT: begin
        if (tick && !sck_ff) begin
          // Rising edge: data bits are sampled after the command
          nxt_sck = 1'h1;
          nxt_bit = bit_ff + 5'h1;
          if (bit_ff >= 5'(`ROM_CMD_BITS)) begin
            nxt_din = {din_ff[14:0], cfg_rom_data_in_i};
          end
        end else if (tick) begin
          nxt_sck = 1'h0;
          nxt_cmd = {cmd_ff[7:0], 1'h0}; // MSB first
          if (bit_ff == 5'(`ROM_EDGES)) begin
            nxt_wr = '{valid: 1'h1, idx: idx_ff, data: din_ff};
            nxt_cs = 1'h0;
            nxt_bit = '0;
            nxt_state = pci_tgt_pkg::LD_GAP;
          end
        end
      end
      pci_tgt_pkg::LD_GAP: begin
        // Deselect for one half period between words
        if (tick && idx_ff == 5'(`ROM_WORDS - 1)) begin
          nxt_state = pci_tgt_pkg::LD_DONE;
          nxt_done = 1'h1;
        end else if (tick) begin
          nxt_idx = idx_ff + 5'h1;
          nxt_cmd = {`ROM_OP_READ, 6'(idx_ff + 5'h1)};
          nxt_cs = 1'h1;
          nxt_state = pci_tgt_pkg::LD_SHIFT;
        end
      end
      pci_tgt_pkg::LD_DONE: nxt_done = 1'h1;
      default: nxt_state = pci_tgt_pkg::LD_STRAP;
    endcase
  end

  // Registers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_ff <= pci_tgt_pkg::LD_STRAP;
      div_ff <= '0;
      bit_ff <= '0;
      idx_ff <= '0;
      cmd_ff <= '0;
      din_ff <= '0;
      cs_ff <= 1'h0;
      sck_ff <= 1'h0;
      wr_ff <= '0;
      done_ff <= 1'h0;
    end else begin
      state_ff <= nxt_state;
      div_ff <= nxt_div;
      bit_ff <= nxt_bit;
      idx_ff <= nxt_idx;
      cmd_ff <= nxt_cmd;
      din_ff <= nxt_din;
      cs_ff <= nxt_cs;
      sck_ff <= nxt_sck;
      wr_ff <= nxt_wr;
      done_ff <= nxt_done;
    end
  end

  assign cfg_rom_select_o = cs_ff;
  assign cfg_rom_clock_o = sck_ff;
  assign cfg_rom_data_out_o = cmd_ff[8];
  assign wr_o = wr_ff;
  assign done_o = done_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_strap_skip: assert property (state_ff == pci_tgt_pkg::LD_STRAP &&
    !cfg_rom_enable_strap_i |=> done_o && !cfg_rom_select_o) else $error("strap ignored");
  a_clock_select: assert property (cfg_rom_clock_o |-> cfg_rom_select_o)
    else $error("rom clock while deselected");
endmodule
`default_nettype wire

// ### pci_host_model.sv
// Bus initiator and serial configuration ROM standing on the far side of the target.
// Assumes the bench resolves the shared lines and calls access() from one thread only.
`timescale 1ns/10ps
`default_nettype none

module pci_host_model (
  // Clock
  input wire logic clk_i,
  // Resolved bus lines
  input wire logic [31:0] ad_i,
  input wire logic par_i,
  input wire logic trdy_n_i,
  input wire logic stop_n_i,
  // Initiator drive
  output logic [31:0] ad_o,
  output logic ad_oe_o,
  output logic par_o,
  output logic par_oe_o,
  output logic [3:0] cbe_n_o,
  output logic frame_n_o,
  output logic irdy_n_o,
  output logic idsel_o,
  // Serial ROM pins
  input wire logic rom_sel_i,
  input wire logic rom_clk_i,
  input wire logic rom_cmd_i,
  output logic rom_dat_o
);
  int edge_cnt; // Rising ROM clock edges in this word
  logic [8:0] cmd_sr; // Opcode and address shifted in
  logic [15:0] dat_sr; // Word shifted out
  logic keep_frame; // Burst wanted: frame held into a second phase

  // Content follows the address asked for, so a wrong address shows in the image
  function automatic logic [15:0] rom_word(input logic [5:0] a);
    return 16'hC300 ^ {a, 2'h1, a, 2'h2};
  endfunction

  // Idle bus at time zero
  initial begin
    {ad_o, ad_oe_o, par_o, par_oe_o, idsel_o, rom_dat_o, keep_frame} = '0;
    {cbe_n_o, frame_n_o, irdy_n_o} = 6'h3F;
    edge_cnt = 0;
  end

  // Command taken on rises, reply chosen after the ninth bit
  always @(posedge rom_clk_i or negedge rom_sel_i) begin
    if (!rom_sel_i) begin
      edge_cnt = 0;
    end else begin
      edge_cnt = edge_cnt + 1;
      if (edge_cnt <= 9) cmd_sr = {cmd_sr[7:0], rom_cmd_i};
      if (edge_cnt == 9) dat_sr = (cmd_sr[8:6] == 3'h6) ? rom_word(cmd_sr[5:0]) : 16'h0000;
    end
  end

  // Data MSB first after each fall; a released line keeps toggling
  always @(negedge rom_clk_i or negedge rom_sel_i) begin
    if (rom_sel_i && edge_cnt >= 9 && edge_cnt < 25) begin
      rom_dat_o = dat_sr[15];
      dat_sr = {dat_sr[14:0], 1'b0};
    end else begin
      rom_dat_o = ~rom_dat_o;
    end
  end

  // One access; res 0 no claim, 1 data moved, 2 retried, 3 moved with stop
  task automatic access(input logic [3:0] cmd, input logic sel, input logic [5:0] idx,
      input logic [31:0] wd, input logic [3:0] be_n, input logic [1:0] bad,
      output logic [31:0] rd, output logic rpar, output int res);
    int n;
    res = 0;
    rd = '0;
    n = 0;
    @(negedge clk_i);
    frame_n_o = 1'b0;
    ad_o = {24'h0, idx, 2'h0};
    ad_oe_o = 1'b1;
    cbe_n_o = cmd;
    idsel_o = sel;
    @(negedge clk_i);
    par_o = ^{ad_o, cbe_n_o} ^ bad[0];
    par_oe_o = 1'b1;
    frame_n_o = !keep_frame; // Drops with irdy up unless a burst is wanted
    irdy_n_o = 1'b0;
    idsel_o = 1'b0;
    cbe_n_o = be_n;
    ad_o = wd;
    ad_oe_o = cmd[0];
    // Wait states bounded; no answer means master abort
    while (res == 0 && n < 8) begin
      @(negedge clk_i);
      n++;
      par_o = ^{wd, be_n} ^ bad[1];
      par_oe_o = cmd[0];
      if (!trdy_n_i) begin
        res = stop_n_i ? 1 : 3;
        rd = ad_i;
      end else if (!stop_n_i) begin
        res = 2;
      end
    end
    @(negedge clk_i);
    rpar = par_i;
    frame_n_o = 1'b1;
    irdy_n_o = 1'b1;
    ad_oe_o = 1'b0;
    cbe_n_o = 4'hF;
    @(negedge clk_i);
    par_oe_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the bus target port and its ROM loader.
// Assumes the host model stands in for initiator and serial ROM.
`timescale 1ns/10ps
`default_nettype none
`include "pci_tgt_defs.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
  $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end

module testbench;
  logic clk_i, reset_i, strap, irq, lock_n, ad_doe, ad_moe, par_d, par_m;
  logic par_doe, par_moe, par_w, par_last, frame_n, irdy_n, idsel, load_done;
  logic trdy_n, trdy_oe, stop_n, stop_oe, devsel_n, devsel_oe, perr_n, perr_oe;
  logic serr_oe, int_oe, rom_sel, rom_clk, rom_cmd, rom_dat, g_rpar;
  logic [31:0] ad_d, ad_m, ad_w, ad_last, g_rd;
  logic [3:0] cbe_n;
  pci_tgt_pkg::cfg_wr_t cfg_wr, last_wr;
  int num_errors, checks, serr_cnt, perr_cnt, wr_cnt, g_res, dsel_cnt;

  // Released lines show a changing pattern; control lines are pulled up
  assign ad_w = ad_doe ? ad_d : (ad_moe ? ad_m : ~ad_last);
  assign par_w = par_doe ? par_d : (par_moe ? par_m : ~par_last);

  pci_target_port #(.ROM_HALF_CYC(2)) i_pci_target_port (
    .clk_i(clk_i), .reset_i(reset_i), .ad_i(ad_w), .ad_o(ad_d), .ad_oe_o(ad_doe),
    .cbe_n_i(cbe_n), .par_i(par_w), .par_o(par_d), .par_oe_o(par_doe),
    .frame_n_i(frame_n), .irdy_n_i(irdy_n), .lock_n_i(lock_n), .idsel_i(idsel),
    .trdy_n_o(trdy_n), .trdy_oe_o(trdy_oe), .stop_n_o(stop_n), .stop_oe_o(stop_oe),
    .devsel_n_o(devsel_n), .devsel_oe_o(devsel_oe), .perr_n_o(perr_n),
    .perr_oe_o(perr_oe), .serr_oe_o(serr_oe), .int_oe_o(int_oe), .irq_i(irq),
    .cfg_rom_enable_strap_i(strap), .cfg_rom_data_in_i(rom_dat),
    .cfg_rom_select_o(rom_sel), .cfg_rom_clock_o(rom_clk), .cfg_rom_data_out_o(rom_cmd),
    .cfg_wr_o(cfg_wr), .load_done_o(load_done));

  pci_host_model i_pci_host_model (
    .clk_i(clk_i), .ad_i(ad_w), .par_i(par_w),
    .trdy_n_i(trdy_oe ? trdy_n : 1'b1), .stop_n_i(stop_oe ? stop_n : 1'b1),
    .ad_o(ad_m), .ad_oe_o(ad_moe), .par_o(par_m), .par_oe_o(par_moe), .cbe_n_o(cbe_n),
    .frame_n_o(frame_n), .irdy_n_o(irdy_n), .idsel_o(idsel), .rom_sel_i(rom_sel),
    .rom_clk_i(rom_clk), .rom_cmd_i(rom_cmd), .rom_dat_o(rom_dat));

  // Clock at 5 ns
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // Pattern memory and event counters, read where outputs are settled
  always @(negedge clk_i) begin
    ad_last <= ad_w;
    par_last <= par_w;
    if (serr_oe === 1'b1) serr_cnt++;
    if (perr_oe === 1'b1 && perr_n === 1'b0) perr_cnt++;
    if (devsel_oe === 1'b1 && stop_oe === 1'b1 && devsel_n === 1'b0) dsel_cnt++;
    if (cfg_wr.valid === 1'b1) begin
      last_wr = cfg_wr;
      wr_cnt++;
    end
  end

  // Counts, verdict, end of run
  task automatic close_out;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Five cycles of reset with the strap at s; nothing driven meanwhile
  task automatic do_reset(input logic s);
    @(negedge clk_i);
    reset_i = 1'b1;
    strap = s;
    repeat (5) @(negedge clk_i);
    `CHK({ad_doe, par_doe, trdy_oe, devsel_oe, serr_oe, rom_sel, load_done}, 7'h00)
    reset_i = 1'b0;
  endtask

  task automatic acc(input logic [3:0] c, input logic s, input logic [5:0] i,
      input logic [31:0] w, input logic [3:0] b, input logic [1:0] bad);
    i_pci_host_model.access(c, s, i, w, b, bad, g_rd, g_rpar, g_res);
  endtask

  // Strap low: defaults at once, ROM untouched, read parity driven
  task automatic t_defaults;
    do_reset(1'b0);
    repeat (3) @(negedge clk_i);
    `CHK({load_done, rom_sel}, 2'b10)
    acc(4'hA, 1'b1, 6'h00, 32'h0, 4'h0, 2'h0);
    `CHK(g_res, 1)
    `CHK(dsel_cnt, 2)
    `CHK(g_rd, {`DEF_DEVICE, `DEF_VENDOR})
    `CHK(g_rpar, ^{g_rd, 4'h0})
    acc(4'hA, 1'b1, 6'h01, 32'h0, 4'h3, 2'h0);
    `CHK(g_rd, 32'h0)
    `CHK(g_rpar, ^{g_rd, 4'h3})
  endtask

  // Unselected and foreign commands are left alone
  task automatic t_reject;
    acc(4'hA, 1'b0, 6'h00, 32'h0, 4'h0, 2'h0);
    `CHK(g_res, 0)
    acc(4'h6, 1'b1, 6'h00, 32'h0, 4'h0, 2'h0);
    `CHK(g_res, 0)
    `CHK(dsel_cnt, 4)
  endtask

  // Write export, byte enables, lock ignored, data and address parity errors
  task automatic t_write;
    int w0, p0, s0;
    w0 = wr_cnt;
    p0 = perr_cnt;
    s0 = serr_cnt;
    lock_n = 1'b0;
    acc(4'hB, 1'b1, 6'h05, 32'hA5C3_0F96, 4'h5, 2'h0);
    lock_n = 1'b1;
    `CHK(g_res, 1)
    `CHK(wr_cnt, w0 + 1)
    `CHK({last_wr.idx, last_wr.data, last_wr.be}, {6'h05, 32'hA5C3_0F96, 4'hA})
    i_pci_host_model.keep_frame = 1'b1;
    acc(4'hB, 1'b1, 6'h07, 32'h0F0F_1234, 4'h3, 2'h0);
    i_pci_host_model.keep_frame = 1'b0;
    `CHK(g_res, 3)
    `CHK(wr_cnt, w0 + 2)
    `CHK(last_wr.be, 4'hC)
    acc(4'hB, 1'b1, 6'h02, 32'h1234_0001, 4'h0, 2'h2);
    repeat (3) @(negedge clk_i);
    `CHK(perr_cnt, p0 + 1)
    acc(4'hA, 1'b1, 6'h00, 32'h0, 4'h0, 2'h1);
    `CHK(serr_cnt, s0 + 1)
    `CHK(perr_cnt, p0 + 1)
  endtask

  // Interrupt line follows the condition a cycle later
  task automatic t_irq;
    irq = 1'b1;
    @(negedge clk_i);
    `CHK(int_oe, 1'b1)
    irq = 1'b0;
    @(negedge clk_i);
    `CHK(int_oe, 1'b0)
  endtask

  // Strap high: retry while loading, then the whole image read back
  task automatic t_rom_load;
    int n;
    do_reset(1'b1);
    acc(4'hA, 1'b1, 6'h00, 32'h0, 4'h0, 2'h0);
    `CHK(g_res, 2)
    `CHK(rom_sel, 1'b1)
    n = 0;
    while (load_done !== 1'b1 && n < 10000) begin
      @(negedge clk_i);
      n++;
    end
    if (load_done !== 1'b1) begin
      num_errors++;
      close_out();
    end
    for (int k = 0; k < 17; k++) begin
      acc(4'hA, 1'b1, k[5:0], 32'h0, 4'h0, 2'h0);
      `CHK(g_rd, (k < 16) ? {i_pci_host_model.rom_word(6'(2 * k + 1)),
          i_pci_host_model.rom_word(6'(2 * k))} : 32'h0)
    end
  endtask

  // Main sequence
  initial begin
    {num_errors, checks, serr_cnt, perr_cnt, wr_cnt, dsel_cnt} = '0;
    {reset_i, strap, irq, lock_n} = 4'b1101;
    {ad_last, par_last} = '0;
    t_defaults();
    t_reject();
    t_write();
    t_irq();
    t_rom_load();
    close_out();
  end
endmodule
`default_nettype wire
